// ### nand_pkg.sv
// Shared constants for the serial NAND die model and its host controller.
// Assumes both ends run on i_clk_sys and meet through spi_link_if.
`default_nettype none
package nand_pkg;
  localparam logic [7:0] OP_COMMIT = 8'h10;
  localparam logic [7:0] OP_LOAD   = 8'h13;
  localparam logic [7:0] OP_READ   = 8'h03;
  localparam logic [7:0] OP_FAST   = 8'h0B;
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_RDSR   = 8'h05;
  localparam logic [7:0] OP_WRSR   = 8'h01;
  localparam logic [7:0] OP_PLOAD  = 8'h02;
  localparam int BUF_BYTES  = 2112;
  localparam int USER_BYTES = 2048;
  localparam int STAT_W     = 8;
  localparam int ST_BUSY    = 0;
  localparam int ST_WEL     = 1;
  localparam int ST_BUF     = 2;
  localparam int ST_ECC     = 3;
  localparam int ST_BP0     = 4;
  localparam int ST_BP2     = 6;
  localparam int ST_TB      = 7;
  localparam logic [7:0] ST_RESET = 8'h0C;
  localparam int HDR_PAGE_BITS   = 32;
  localparam int HDR_COL_BITS    = 24;
  localparam int DUMMY_SHORT     = 8;
  localparam int DUMMY_READ_LONG = 24;
  localparam int DUMMY_FAST_LONG = 32;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int SCLK_PERIOD_NS = 32;
  localparam int SCLK_HALF      = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int APB_AW  = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ADDR = 8'h04;
  localparam logic [7:0] A_LEN  = 8'h08;
  localparam logic [7:0] A_SEED = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_RXD  = 8'h14;
  localparam int CTRL_GO = 8;
  typedef enum logic [2:0] {ENG_IDLE = 3'b001, ENG_PROG = 3'b010, ENG_LOAD = 3'b100} eng_type;
  typedef enum logic [2:0] {H_IDLE = 3'b001, H_RUN = 3'b010, H_TAIL = 3'b100} host_st_type;

  // Bit count after which read data starts
  function automatic logic [7:0] read_start(input logic [7:0] op, input logic bufm);
    if (bufm) return 8'(HDR_COL_BITS + DUMMY_SHORT);
    if (op == OP_FAST) return 8'(HDR_COL_BITS + DUMMY_FAST_LONG);
    return 8'(HDR_COL_BITS + DUMMY_READ_LONG);
  endfunction
endpackage
`default_nettype wire

// ### spi_link_if.sv
// Single-bit serial link between host controller and NAND die.
// Assumes both ends are clocked by i_clk_sys; data line has a pull-up.
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic di;
  logic do_val;
  logic do_oe_n;
  logic miso;
  // Released line reads high, as through a pull-up
  assign miso = do_oe_n ? 1'b1 : do_val;
  modport device (input cs_n, input sclk, input di, output do_val, output do_oe_n);
  modport host (output cs_n, output sclk, output di, input miso);
endinterface
`default_nettype wire

// ### nand_die_dev.sv
// Serial NAND die: commit, page load, buffer read-out and status.
// Assumes link pins are driven by logic on i_clk_sys, so no synchroniser.
`timescale 1ns/100ps
`default_nettype none
module nand_die_dev #(
  parameter int ARR_PAGES  = 4,
  parameter int BUSY_EXTRA = 16
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_srst,
  spi_link_if.device                       link,
  output logic [nand_pkg::STAT_W-1:0]      o_status
);
  import nand_pkg::*;

  localparam int AW = $clog2(ARR_PAGES * BUF_BYTES);
  localparam int CW = $clog2(BUF_BYTES + BUSY_EXTRA);

  logic [7:0]    dbuf [BUF_BYTES];
  logic [7:0]    arr  [ARR_PAGES * BUF_BYTES];
  eng_type       eng_r;
  logic [CW-1:0] eng_cnt_r;
  logic [15:0]   eng_pg_r;
  logic [15:0]   buf_pg_r;
  logic [15:0]   rd_pg_r;
  logic [15:0]   in_sr_r;
  logic [15:0]   sr_nxt;
  logic [11:0]   col_r;
  logic [7:0]    bit_cnt_r;
  logic [7:0]    op_r;
  logic [7:0]    out_sr_r;
  logic [7:0]    ecc_acc_r;
  logic [7:0]    src_byte;
  logic [7:0]    status;
  logic [7:2]    cfg_r;
  logic [2:0]    ob_cnt_r;
  logic          wel_r;
  logic          sclk_q_r;
  logic          cs_q_r;
  logic          from_buf_r;
  logic          do_r;
  logic          oe_n_r;
  logic          rise;
  logic          fall;
  logic          cs_rise;
  logic          busy;
  logic          bufm;
  logic          rd_op;
  logic          out_phase;
  logic          wr_byte;
  logic          eng_done;
  logic          frame32;

  function automatic logic [AW-1:0] aidx(input logic [15:0] pg, input int col);
    return AW'((int'(pg) % ARR_PAGES) * BUF_BYTES + col);
  endfunction

  // Top/bottom plus three-bit level; level n guards 2**(n-1) pages
  function automatic logic prot(input logic [15:0] pg, input logic [7:2] c);
    int lvl;
    int span;
    int p;
    lvl  = int'(c[ST_BP2:ST_BP0]);
    span = (lvl == 0) ? 0 : (1 << (lvl - 1));
    p    = int'(pg) % ARR_PAGES;
    return c[ST_TB] ? (p < span) : (p >= ARR_PAGES - span);
  endfunction

  assign busy      = (eng_r != ENG_IDLE);
  assign status    = {cfg_r, wel_r, busy};
  assign o_status  = status;
  assign bufm      = cfg_r[ST_BUF];
  assign rise      = link.sclk & ~sclk_q_r & ~link.cs_n;
  assign fall      = ~link.sclk & sclk_q_r & ~link.cs_n;
  assign cs_rise   = link.cs_n & ~cs_q_r;
  assign sr_nxt    = {in_sr_r[14:0], link.di};
  assign frame32   = cs_rise && bit_cnt_r == 8'(HDR_PAGE_BITS);
  assign eng_done  = (eng_cnt_r == CW'(BUF_BYTES + BUSY_EXTRA - 1));
  assign rd_op     = (op_r == OP_READ || op_r == OP_FAST) && !busy;
  // Status reads bypass the busy gate
  assign out_phase = rd_op ? (bit_cnt_r >= read_start(op_r, bufm))
                           : (op_r == OP_RDSR && bit_cnt_r >= 8'h08);
  assign wr_byte   = rise && op_r == OP_PLOAD && bit_cnt_r >= 8'h1F
                     && bit_cnt_r[2:0] == 3'h7 && wel_r && !busy;
  assign src_byte  = (op_r == OP_RDSR) ? status
                   : from_buf_r ? dbuf[col_r] : arr[aidx(rd_pg_r, int'(col_r))];
  assign link.do_val  = do_r;
  assign link.do_oe_n = oe_n_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sclk_q_r <= 1'b0;
      cs_q_r   <= 1'b1;
    end else begin
      sclk_q_r <= link.sclk;
      cs_q_r   <= link.cs_n;
    end
  end

  // Counter wraps 255 to 248 so byte phase survives long frames
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || cs_rise) begin
      bit_cnt_r <= 8'h00;
      in_sr_r   <= 16'h0000;
      op_r      <= 8'h00;
    end else if (rise) begin
      in_sr_r   <= sr_nxt;
      bit_cnt_r <= (bit_cnt_r == 8'hFF) ? 8'hF8 : bit_cnt_r + 8'h01;
      if (bit_cnt_r == 8'h07) begin
        op_r <= sr_nxt[7:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cfg_r <= ST_RESET[7:2];
      wel_r <= 1'b0;
    end else begin
      if (rise && bit_cnt_r == 8'h0F && op_r == OP_WRSR && !busy) begin
        cfg_r <= sr_nxt[7:2];
      end
      if (rise && bit_cnt_r == 8'h07 && sr_nxt[7:0] == OP_WREN && !busy) begin
        wel_r <= 1'b1;
      end else if (eng_r == ENG_PROG && eng_done) begin
        wel_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      eng_r     <= ENG_IDLE;
      eng_cnt_r <= '0;
      eng_pg_r  <= 16'h0000;
      buf_pg_r  <= 16'h0000;
      ecc_acc_r <= 8'h00;
    end else begin
      unique case (eng_r)
        ENG_IDLE: begin
          eng_cnt_r <= '0;
          ecc_acc_r <= 8'h00;
          if (frame32 && op_r == OP_COMMIT && !prot(in_sr_r, cfg_r)) begin
            eng_r    <= ENG_PROG;
            eng_pg_r <= in_sr_r;
          end else if (frame32 && op_r == OP_LOAD) begin
            eng_r    <= ENG_LOAD;
            eng_pg_r <= in_sr_r;
            buf_pg_r <= in_sr_r;
          end
        end
        ENG_PROG, ENG_LOAD: begin
          eng_cnt_r <= eng_cnt_r + CW'(1);
          if (eng_r == ENG_PROG && eng_cnt_r < CW'(USER_BYTES)) begin
            ecc_acc_r <= ecc_acc_r ^ dbuf[eng_cnt_r];
          end
          if (eng_done) begin
            eng_r <= ENG_IDLE;
          end
        end
      endcase
    end
  end

  // One byte per cycle; busy window always covers the copy
  always_ff @(posedge i_clk_sys) begin
    if (wr_byte && col_r < 12'(BUF_BYTES)) begin
      dbuf[col_r] <= sr_nxt[7:0];
    end
    if (eng_r == ENG_LOAD && eng_cnt_r < CW'(BUF_BYTES)) begin
      dbuf[eng_cnt_r] <= arr[aidx(eng_pg_r, int'(eng_cnt_r))];
    end
  end

  // Spare bytes take parity over user bytes when ECC is on
  always_ff @(posedge i_clk_sys) begin
    if (eng_r == ENG_PROG && eng_cnt_r < CW'(BUF_BYTES)) begin
      arr[aidx(eng_pg_r, int'(eng_cnt_r))] <=
        (cfg_r[ST_ECC] && eng_cnt_r >= CW'(USER_BYTES)) ? ecc_acc_r : dbuf[eng_cnt_r];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      col_r      <= 12'h000;
      rd_pg_r    <= 16'h0000;
      from_buf_r <= 1'b1;
    end else if (rise && bit_cnt_r == 8'h17) begin
      col_r      <= (bufm || op_r == OP_PLOAD) ? sr_nxt[11:0] : 12'h000;
      rd_pg_r    <= buf_pg_r;
      from_buf_r <= 1'b1;
    end else if (wr_byte) begin
      col_r <= col_r + 12'h001;
    end else if (fall && out_phase && ob_cnt_r == 3'h0 && op_r != OP_RDSR) begin
      if (!bufm && col_r == 12'(BUF_BYTES - 1)) begin
        col_r      <= 12'h000;
        rd_pg_r    <= rd_pg_r + 16'h0001;
        from_buf_r <= 1'b0;
      end else if (col_r < 12'(BUF_BYTES)) begin
        col_r <= col_r + 12'h001;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || cs_rise) begin
      do_r     <= 1'b0;
      oe_n_r   <= 1'b1;
      out_sr_r <= 8'h00;
      ob_cnt_r <= 3'h0;
    end else if (fall && out_phase) begin
      ob_cnt_r <= ob_cnt_r + 3'h1;
      if (ob_cnt_r == 3'h0) begin
        if (op_r != OP_RDSR && bufm && col_r >= 12'(BUF_BYTES)) begin
          oe_n_r <= 1'b1;
        end else begin
          do_r     <= src_byte[7];
          out_sr_r <= {src_byte[6:0], 1'b0};
          oe_n_r   <= 1'b0;
        end
      end else begin
        do_r     <= out_sr_r[7];
        out_sr_r <= {out_sr_r[6:0], 1'b0};
      end
    end
  end
endmodule // nand_die_dev
`default_nettype wire

// ### nand_host_ctl.sv
// Host side: APB-programmed frame engine and receive FIFO.
// Assumes an APB master on i_clk_sys and the die across spi_link_if.
`timescale 1ns/100ps
`default_nettype none
module sync_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_srst,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  cnt_r;
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic         wr;
  logic         rd;

  // Depth must be a power of two for pointer wrap
  assign o_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_valid = (cnt_r != '0);
  assign o_data  = mem[rp_r];
  assign wr      = i_valid & o_ready;
  assign rd      = o_valid & i_ready;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_r + AW'(wr);
      rp_r  <= rp_r + AW'(rd);
      cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (wr) begin
      mem[wp_r] <= i_data;
    end
  end
endmodule // sync_fifo

module nand_host_ctl #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_srst,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [nand_pkg::APB_AW-1:0] i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  output logic [31:0]                      o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  spi_link_if.host                         link
);
  import nand_pkg::*;

  host_st_type st_r;
  logic [31:0] out_sr_r;
  logic [31:0] hdr;
  logic [15:0] addr_r;
  logic [15:0] bits_r;
  logic [15:0] total_r;
  logic [15:0] pre_r;
  logic [15:0] pre;
  logic [11:0] len_r;
  logic [7:0]  op_r;
  logic [7:0]  seed_r;
  logic [7:0]  div_r;
  logic [7:0]  rx_sr_r;
  logic [7:0]  txb_r;
  logic [7:0]  push_data;
  logic [7:0]  f_data;
  logic [7:0]  new_op;
  logic        sclk_r;
  logic        cs_n_r;
  logic        rx_r;
  logic        tx_r;
  logic        buf_r;
  logic        err_r;
  logic        pop_ok_r;
  logic        go;
  logic        stall;
  logic        rise_ev;
  logic        push;
  logic        f_in_rdy;
  logic        f_valid;
  logic        new_rx;
  logic        new_tx;

  assign new_op  = i_pwdata[7:0];
  assign go      = i_psel && i_penable && i_pwrite && i_paddr == A_CTRL
                   && i_pwdata[CTRL_GO] && st_r == H_IDLE;
  assign new_rx  = (new_op == OP_READ || new_op == OP_FAST || new_op == OP_RDSR);
  assign new_tx  = (new_op == OP_PLOAD || new_op == OP_WRSR);
  assign pre     = (new_op == OP_COMMIT || new_op == OP_LOAD) ? 16'(HDR_PAGE_BITS)
                 : (new_op == OP_READ || new_op == OP_FAST) ? 16'(read_start(new_op, buf_r))
                 : (new_op == OP_PLOAD) ? 16'(HDR_COL_BITS) : 16'h0008;
  assign hdr     = (new_op == OP_COMMIT || new_op == OP_LOAD) ? {new_op, 8'h00, addr_r}
                 : {new_op, addr_r, 8'h00};
  assign stall   = rx_r && bits_r >= pre_r && bits_r[2:0] == 3'h0 && !f_in_rdy;
  assign rise_ev = st_r == H_RUN && div_r == 8'(SCLK_HALF - 1) && !sclk_r && !stall;
  assign push    = rise_ev && rx_r && bits_r >= pre_r && bits_r[2:0] == 3'h7;
  assign push_data = {rx_sr_r[6:0], link.miso};
  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.di   = out_sr_r[31];
  assign o_pready  = 1'b1;
  assign o_pslverr = err_r;

  // Full FIFO holds the clock low, pausing the die's stream
  sync_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_valid   (push),
    .o_ready   (f_in_rdy),
    .i_data    (push_data),
    .o_valid   (f_valid),
    .i_ready   (i_psel & i_penable & pop_ok_r),
    .o_data    (f_data)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      op_r   <= 8'h00;
      addr_r <= 16'h0000;
      len_r  <= 12'h000;
      seed_r <= 8'h00;
    end else if (i_psel && i_penable && i_pwrite) begin
      if (i_paddr == A_CTRL && st_r == H_IDLE) op_r <= new_op;
      if (i_paddr == A_ADDR) addr_r <= i_pwdata[15:0];
      if (i_paddr == A_LEN) len_r <= i_pwdata[11:0];
      if (i_paddr == A_SEED) seed_r <= i_pwdata[7:0];
    end
  end

  // Mirrors the die's read-mode bit from what passes the link
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      buf_r <= ST_RESET[ST_BUF];
    end else if (go && new_op == OP_WRSR) begin
      buf_r <= seed_r[ST_BUF];
    end else if (push && op_r == OP_RDSR) begin
      buf_r <= push_data[ST_BUF];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_r     <= H_IDLE;
      cs_n_r   <= 1'b1;
      sclk_r   <= 1'b0;
      div_r    <= 8'h00;
      bits_r   <= 16'h0000;
      total_r  <= 16'h0000;
      pre_r    <= 16'h0000;
      out_sr_r <= 32'h00000000;
      rx_sr_r  <= 8'h00;
      txb_r    <= 8'h00;
      rx_r     <= 1'b0;
      tx_r     <= 1'b0;
    end else begin
      unique case (st_r)
        H_IDLE: begin
          div_r <= 8'h00;
          if (go) begin
            st_r     <= H_RUN;
            cs_n_r   <= 1'b0;
            bits_r   <= 16'h0000;
            pre_r    <= pre;
            total_r  <= pre + ((new_rx || new_tx) ? {1'b0, len_r, 3'h0} : 16'h0000);
            out_sr_r <= hdr;
            txb_r    <= seed_r;
            rx_r     <= new_rx;
            tx_r     <= new_tx;
          end
        end
        H_RUN: begin
          if (div_r != 8'(SCLK_HALF - 1)) begin
            div_r <= div_r + 8'h01;
          end else if (!sclk_r) begin
            if (!stall) begin
              div_r   <= 8'h00;
              sclk_r  <= 1'b1;
              rx_sr_r <= push_data;
              bits_r  <= bits_r + 16'h0001;
            end
          end else begin
            div_r  <= 8'h00;
            sclk_r <= 1'b0;
            if (bits_r == total_r) begin
              st_r <= H_TAIL;
            end else if (tx_r && bits_r >= pre_r && bits_r[2:0] == 3'h0) begin
              out_sr_r <= {txb_r, 24'h000000};
              txb_r    <= txb_r + 8'h01;
            end else begin
              out_sr_r <= {out_sr_r[30:0], 1'b0};
            end
          end
        end
        H_TAIL: begin
          if (div_r != 8'(SCLK_HALF - 1)) begin
            div_r <= div_r + 8'h01;
          end else begin
            cs_n_r <= 1'b1;
            st_r   <= H_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_prdata <= 32'h00000000;
      err_r    <= 1'b0;
      pop_ok_r <= 1'b0;
    end else if (i_psel && !i_penable) begin
      err_r    <= 1'b0;
      pop_ok_r <= 1'b0;
      case (i_paddr)
        A_CTRL: o_prdata <= {24'h000000, op_r};
        A_ADDR: o_prdata <= {16'h0000, addr_r};
        A_LEN:  o_prdata <= {20'h00000, len_r};
        A_SEED: o_prdata <= {24'h000000, seed_r};
        A_STAT: o_prdata <= {29'h00000000, buf_r, f_valid, st_r != H_IDLE};
        A_RXD: begin
          o_prdata <= {23'h000000, f_valid, f_data};
          pop_ok_r <= f_valid & ~i_pwrite;
        end
        default: begin
          o_prdata <= 32'h00000000;
          err_r    <= 1'b1;
        end
      endcase
    end
  end
endmodule // nand_host_ctl
`default_nettype wire

// ### nand_link_checker.sv
// Assertions on the serial link and die status.
// Assumes all signals sampled on i_clk_sys.
`timescale 1ns/100ps
`default_nettype none
module nand_link_checker #(
  parameter int BUSY_EXTRA = 16
) (
  input wire logic       i_clk_sys,
  input wire logic       i_srst,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       di,
  input wire logic       do_val,
  input wire logic       do_oe_n,
  input wire logic       miso,
  input wire logic [7:0] o_status
);
  import nand_pkg::*;
  logic [15:0] busy_cnt_r;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // Counter, since busy spans thousands of cycles
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !o_status[ST_BUSY]) busy_cnt_r <= 16'h0000;
    else busy_cnt_r <= busy_cnt_r + 16'h0001;
  end
  a_busy_after_cs: assert property ($rose(o_status[ST_BUSY]) |-> cs_n && $past(cs_n))
    else $error("busy began inside a frame");
  a_busy_length: assert property ($fell(o_status[ST_BUSY]) |-> busy_cnt_r == 16'(BUF_BYTES + BUSY_EXTRA))
    else $error("busy period has wrong length");
  a_oe_off_idle: assert property (cs_n && $past(cs_n) |-> do_oe_n)
    else $error("output enabled outside a frame");
  a_miso_pull_up: assert property (do_oe_n |-> miso)
    else $error("released line not high");
  // Mode and protect bits may only move while a frame is open
  a_cfg_frame_only: assert property (cs_n && $past(cs_n) |-> $stable(o_status[7:2]))
    else $error("config bits moved outside a frame");
  a_do_on_low: assert property ($changed(do_val) && !do_oe_n |-> !sclk)
    else $error("data changed while clock high");
  a_oe_on_fall: assert property ($fell(do_oe_n) |-> !sclk && !cs_n)
    else $error("output enabled off a falling clock");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock not idle low");
  a_sclk_high_two: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("serial clock high phase wrong");
  a_di_steady: assert property ($rose(sclk) |-> $stable(di))
    else $error("data in moved at rising clock");
endmodule // nand_link_checker
`default_nettype wire

// ### tb_serial_nand_page_program_read.sv
// Bench for host controller and die joined by the link.
// Assumes the package, interface and both ends compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_serial_nand_page_program_read;
  import nand_pkg::*;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  status;
  logic [31:0] rdata;
  logic [7:0]  exp_q[$];
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [7:0]  s0;
  logic [7:0]  s2;
  logic [15:0] pg;
  logic [15:0] col;
  spi_link_if link();
  always #4 clk_sys = ~clk_sys;
  nand_die_dev #(.ARR_PAGES(4), .BUSY_EXTRA(8)) i_nand_die_dev (.i_clk_sys(clk_sys), .i_srst(srst),
    .link(link), .o_status(status));
  nand_host_ctl #(.FIFO_DEPTH(4)) i_nand_host_ctl (.i_clk_sys(clk_sys), .i_srst(srst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .link(link));
  nand_link_checker #(.BUSY_EXTRA(8)) i_nand_link_checker (.i_clk_sys(clk_sys), .i_srst(srst),
    .cs_n(link.cs_n), .sclk(link.sclk), .di(link.di), .do_val(link.do_val), .do_oe_n(link.do_oe_n),
    .miso(link.miso), .o_status(status));

  task automatic finish_test();
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Drains the small FIFO while the frame runs, else the host stalls
  task automatic frame(input logic [7:0] op, input logic [15:0] a, input logic [11:0] len,
                       input logic [7:0] sd, input int rxn);
    int   got;
    logic busy;
    got = 0;
    busy = 1'b1;
    apb(1'b1, A_ADDR, {16'h0000, a});
    apb(1'b1, A_LEN, {20'h00000, len});
    apb(1'b1, A_SEED, {24'h000000, sd});
    apb(1'b1, A_CTRL, {23'h000000, 1'b1, op});
    while (busy || got < rxn) begin
      apb(1'b0, A_RXD, 32'h0);
      if (rdata[8] === 1'b1) got++;
      apb(1'b0, A_STAT, 32'h0);
      busy = rdata[0] !== 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] op, input logic [15:0] c, input logic [7:0] base, input int n);
    for (int k = 0; k < n; k++) exp_q.push_back(base + 8'(k));
    frame(op, c, 12'(n), 8'h00, n);
  endtask

  task automatic wait_idle();
    while (status[ST_BUSY] !== 1'b0) @(posedge clk_sys);
  endtask

  // Result watcher: each popped byte against the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && paddr == A_RXD && prdata[8] === 1'b1) begin
      chk(prdata[7:0], exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    s0 = 8'($urandom(32'hece474ad));
    s2 = 8'($urandom());
    pg = 16'(1 + $urandom_range(2));
    col = 16'($urandom_range(7));
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    chk(status, ST_RESET);
    apb(1'b0, 8'h20, 32'h0);
    chk({7'h00, pslverr}, 8'h01);
    frame(OP_WREN, 16'h0, 12'h0, 8'h00, 0);
    chk(status, 8'h0E);
    frame(OP_PLOAD, 16'h0, 12'd16, s0, 0);
    frame(OP_COMMIT, pg, 12'h0, 8'h00, 0);
    chk(status, 8'h0F);
    rd(OP_RDSR, 16'h0, 8'h0F, 1);
    wait_idle();
    chk(status, 8'h0C);
    frame(OP_PLOAD, 16'h0, 12'd8, ~s0, 0);
    rd(OP_READ, col, s0 + col[7:0], 8);
    frame(OP_WREN, 16'h0, 12'h0, 8'h00, 0);
    frame(OP_PLOAD, 16'h0, 12'd8, ~s0, 0);
    frame(OP_LOAD, pg, 12'h0, 8'h00, 0);
    chk(status, 8'h0F);
    rd(OP_RDSR, 16'h0, 8'h0F, 1);
    wait_idle();
    rd(OP_READ, col, s0 + col[7:0], 8);
    rd(OP_FAST, col, s0 + col[7:0], 8);
    frame(OP_PLOAD, 16'd2110, 12'd2, s2, 0);
    for (int k = 0; k < 4; k++) exp_q.push_back(k < 2 ? s2 + 8'(k) : 8'hFF);
    frame(OP_READ, 16'd2110, 12'd4, 8'h00, 4);
    frame(OP_WRSR, 16'h0, 12'd1, 8'h08, 0);
    chk(status, 8'h0A);
    rd(OP_READ, 16'd2110, s0, 4);
    rd(OP_FAST, col, s0, 4);
    frame(OP_WRSR, 16'h0, 12'd1, 8'h9C, 0);
    frame(OP_COMMIT, 16'h0, 12'h0, 8'h00, 0);
    chk(status, 8'h9E);
    chk(8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule // tb_serial_nand_page_program_read
`default_nettype wire
